// *** design/fmbcc_pkg.sv ***
// Constants and carrier types for the flash map, boot and clock configuration block
`default_nettype none
package fmbcc_pkg;
	localparam int          FLASH_AW          = 17;
	localparam int          BLOCK_AW          = 12;
	localparam int          BLOCK_BYTES       = 4096;
	localparam int          TOTAL_BLOCKS      = 18;
	localparam int          FLASH_DEPTH       = TOTAL_BLOCKS * BLOCK_BYTES;
	localparam logic [4:0]  LAST_USER_BLOCK   = 5'h0f;
	localparam logic [4:0]  STATUS_BLOCK      = 5'h10;
	localparam logic [4:0]  SECURITY_BLOCK    = 5'h11;
	localparam logic [16:0] CHIP_LAST_ADDR    = 17'h1_1fff;
	localparam logic [11:0] BLOCK_LAST_OFFSET = 12'hfff;
	localparam logic [11:0] CFG_OFFSET        = 12'h000;
	localparam logic [11:0] STATUS_OFFSET     = 12'h000;
	localparam logic [11:0] VECTOR_OFFSET     = 12'h001;
	localparam int          PROT_LSB          = 0;
	localparam int          PROT_BITS         = 3;
	localparam int          FX2_BIT           = 3;
	localparam logic [7:0]  ERASED_BYTE       = 8'hff;
	localparam logic [2:0]  PROT_ERASED       = 3'h7;
	localparam logic [15:0] BOOT_ROM_BASE     = 16'hfc00;
	localparam logic [15:0] RESET_START       = 16'h0000;
	localparam logic [7:0]  START_LOW_BYTE    = 8'h00;
	localparam int          CLK_PERIOD_NS     = 100;
	localparam int          PROG_TIME_NS      = 8000;
	localparam int          PROG_CYCLES       = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ERASE_TIME_MS     = 3000;
	localparam int          CHIP_ERASE_TIME_MS = 11000;
	localparam int          CYCLES_PER_MS     = 1000000 / CLK_PERIOD_NS;
	localparam int          ERASE_CYCLES      = ERASE_TIME_MS * CYCLES_PER_MS;
	localparam int          CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_MS * CYCLES_PER_MS;
	localparam logic [31:0] DIV_TWELVE        = 32'h0000_000c;
	localparam logic [31:0] DIV_SIX           = 32'h0000_0006;

	typedef enum logic [2:0] {
		OP_BLOCK_ERASE,
		OP_CHIP_ERASE,
		OP_PROGRAM,
		OP_VERIFY,
		OP_READ,
		OP_PROTECT
	} fmbcc_op_type;

	typedef enum logic [1:0] {
		SRC_USER_FLASH,
		SRC_BOOT_ROM,
		SRC_EXTERNAL
	} fmbcc_fetch_type;

	typedef struct packed {
		fmbcc_op_type         op;
		logic                 parallel;
		logic [4:0]           block;
		logic [FLASH_AW-1:0]  addr;
		logic [7:0]           data;
	} fmbcc_cmd_type;

	typedef struct packed {
		logic       done;
		logic       rejected;
		logic       verify_ok;
		logic [7:0] rdata;
	} fmbcc_rsp_type;
endpackage
`default_nettype wire

// *** design/fmbcc_flash_mem.sv ***
// Byte-wide flash array with one write port and two registered read ports
`default_nettype none
module fmbcc_flash_mem #(
	parameter int AW    = 17,
	parameter int DEPTH = 73728
) (
	// Clock
	input  wire logic          sys_clk,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// Read ports
	input  wire logic [AW-1:0] raddr_a,
	output var  logic [7:0]    rdata_a,
	input  wire logic [AW-1:0] raddr_b,
	output var  logic [7:0]    rdata_b
);
	logic [7:0] cells [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (we)
			cells[waddr] <= wdata;
		rdata_a <= cells[raddr_a];
		rdata_b <= cells[raddr_b];
	end
endmodule
`default_nettype wire

// *** design/fmbcc_down_timer.sv ***
// Loadable down counter that flags zero
`default_nettype none
module fmbcc_down_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output wire logic         count_zero
);
	logic [W-1:0] count;

	assign count_zero = (count == '0);

	always_ff @(posedge sys_clk) begin
		if (reset)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (!count_zero)
			count <= count - 1'b1;
	end
endmodule
`default_nettype wire

// *** design/fmbcc_flash_ctrl.sv ***
// Program flash controller: erase, program, boot start, overlay and clock mode
`default_nettype none
module fmbcc_flash_ctrl
	import fmbcc_pkg::*;
#(
	parameter int ERASE_TIME_CYCLES      = ERASE_CYCLES,
	parameter int CHIP_ERASE_TIME_CYCLES = CHIP_ERASE_CYCLES
) (
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            reset,
	// Command request and answer
	input  wire logic            cmd_valid,
	input  wire fmbcc_cmd_type   cmd,
	output var  fmbcc_rsp_type   rsp,
	output var  logic            busy,
	// Code fetch
	input  wire logic            fetch_req,
	input  wire logic [15:0]     fetch_addr,
	input  wire logic            boot_rom_enable,
	input  wire logic            external_access_input_n,
	output var  logic            fetch_valid,
	output var  fmbcc_fetch_type fetch_source,
	output wire logic [7:0]      fetch_data,
	// Boot start
	output var  logic            boot_ready,
	output var  logic [15:0]     start_address,
	// Clock mode and protection bits
	input  wire logic            register_clock_mode_bit,
	output var  logic            six_clock_mode,
	output var  logic            machine_cycle_tick,
	output var  logic [2:0]      protection_bits
);
	typedef enum logic [3:0] {
		ST_BOOT_CFG,
		ST_BOOT_STAT,
		ST_BOOT_VEC,
		ST_BOOT_END,
		ST_IDLE,
		ST_ERASE,
		ST_PROT_RD,
		ST_READ,
		ST_WAIT
	} fmbcc_state_type;

	localparam logic [FLASH_AW-1:0] CFG_ADDR    = {SECURITY_BLOCK, CFG_OFFSET};
	localparam logic [FLASH_AW-1:0] STATUS_ADDR = {STATUS_BLOCK, STATUS_OFFSET};
	localparam logic [FLASH_AW-1:0] VECTOR_ADDR = {STATUS_BLOCK, VECTOR_OFFSET};
	localparam logic [31:0] PROG_LOAD  = 32'(PROG_CYCLES - 2);
	localparam logic [31:0] ERASE_LOAD = 32'(ERASE_TIME_CYCLES - 2);
	localparam logic [31:0] CHIP_LOAD  = 32'(CHIP_ERASE_TIME_CYCLES - 2);

	fmbcc_state_type     state;
	fmbcc_state_type     next_state;
	fmbcc_cmd_type       held_cmd;
	logic [FLASH_AW-1:0] walk_addr;
	logic [FLASH_AW-1:0] walk_end;
	logic                ea_meta;
	logic                ea_sync_n;
	logic                fx2_programmed;
	logic [7:0]          status_byte;

	wire logic [7:0] rdata_a;
	wire logic [7:0] rdata_b;
	wire logic       op_timer_zero;
	wire logic       div_zero;

	// Command screening
	wire logic idle       = (state == ST_IDLE);
	wire logic prot_set   = (protection_bits != PROT_ERASED);
	wire logic byte_op    = (cmd.op == OP_PROGRAM) || (cmd.op == OP_READ) || (cmd.op == OP_VERIFY);
	wire logic bad_block  = (cmd.op == OP_BLOCK_ERASE) && (cmd.block > STATUS_BLOCK);
	wire logic bad_addr   = byte_op && (cmd.addr[FLASH_AW-1:BLOCK_AW] > SECURITY_BLOCK);
	wire logic locked_out = cmd.parallel && prot_set && (cmd.op != OP_CHIP_ERASE);
	wire logic cmd_bad    = bad_block || bad_addr || locked_out;
	wire logic accept     = cmd_valid && idle && !cmd_bad;
	wire logic refuse     = cmd_valid && !(idle && !cmd_bad);

	// Erase extent: one block or the whole array
	wire logic [FLASH_AW-1:0] blk_base  = {cmd.block, {BLOCK_AW{1'b0}}};
	wire logic [FLASH_AW-1:0] blk_last  = {cmd.block, BLOCK_LAST_OFFSET};
	wire logic                is_chip   = (cmd.op == OP_CHIP_ERASE);
	wire logic [FLASH_AW-1:0] erase_beg = is_chip ? '0 : blk_base;
	wire logic [FLASH_AW-1:0] erase_end = is_chip ? CHIP_LAST_ADDR : blk_last;

	// Operation timer load
	wire logic        timer_load = accept && (cmd.op != OP_READ) && (cmd.op != OP_VERIFY);
	wire logic [31:0] timer_value = is_chip ? CHIP_LOAD :
		(cmd.op == OP_BLOCK_ERASE) ? ERASE_LOAD : PROG_LOAD;

	// Array write selection
	wire logic [2:0] prot_clear = 3'(1) << held_cmd.data[1:0];
	wire logic [7:0] prot_byte  = rdata_a & ~{5'h00, prot_clear};
	wire logic       mem_we     = (state == ST_ERASE) || (state == ST_PROT_RD) || (accept && cmd.op == OP_PROGRAM);
	wire logic [FLASH_AW-1:0] mem_waddr = (state == ST_ERASE) ? walk_addr :
		(state == ST_PROT_RD) ? CFG_ADDR : cmd.addr;
	wire logic [7:0] mem_wdata = (state == ST_ERASE) ? ERASED_BYTE :
		(state == ST_PROT_RD) ? prot_byte : cmd.data;

	// Array read selection
	wire logic [FLASH_AW-1:0] mem_raddr =
		(state == ST_BOOT_CFG)  ? CFG_ADDR :
		(state == ST_BOOT_STAT) ? STATUS_ADDR :
		(state == ST_BOOT_VEC)  ? VECTOR_ADDR :
		(cmd.op == OP_PROTECT)  ? CFG_ADDR : cmd.addr;

	// Code space routing
	wire logic            in_overlay = boot_rom_enable && (fetch_addr >= BOOT_ROM_BASE);
	wire fmbcc_fetch_type next_source = !ea_sync_n ? SRC_EXTERNAL :
		in_overlay ? SRC_BOOT_ROM : SRC_USER_FLASH;

	// Clock mode
	wire logic        next_six = fx2_programmed || register_clock_mode_bit;
	wire logic [31:0] div_value = (next_six ? DIV_SIX : DIV_TWELVE) - 32'h0000_0001;

	// Write to the configuration byte mirrored in the live protection state
	wire logic cfg_write = accept && (cmd.op == OP_PROGRAM) && (cmd.addr == CFG_ADDR);

	assign fetch_data = rdata_b;

	fmbcc_flash_mem #(
		.AW    (FLASH_AW),
		.DEPTH (FLASH_DEPTH)
	) u_array (
		.sys_clk (sys_clk),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.raddr_a (mem_raddr),
		.rdata_a (rdata_a),
		.raddr_b ({1'b0, fetch_addr}),
		.rdata_b (rdata_b)
	);

	fmbcc_down_timer #(.W(32)) u_op_timer (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.load       (timer_load),
		.load_value (timer_value),
		.count_zero (op_timer_zero)
	);

	fmbcc_down_timer #(.W(32)) u_cycle_div (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.load       (div_zero),
		.load_value (div_value),
		.count_zero (div_zero)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_BOOT_CFG:  next_state = ST_BOOT_STAT;
			ST_BOOT_STAT: next_state = ST_BOOT_VEC;
			ST_BOOT_VEC:  next_state = ST_BOOT_END;
			ST_BOOT_END:  next_state = ST_IDLE;
			ST_IDLE: begin
				if (accept) begin
					case (cmd.op)
						OP_BLOCK_ERASE: next_state = ST_ERASE;
						OP_CHIP_ERASE:  next_state = ST_ERASE;
						OP_PROTECT:     next_state = ST_PROT_RD;
						OP_PROGRAM:     next_state = ST_WAIT;
						default:        next_state = ST_READ;
					endcase
				end
			end
			ST_ERASE:   if (walk_addr == walk_end) next_state = ST_WAIT;
			ST_PROT_RD: next_state = ST_WAIT;
			ST_READ:    next_state = ST_IDLE;
			ST_WAIT:    if (op_timer_zero) next_state = ST_IDLE;
			default:    next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= ST_BOOT_CFG;
			busy  <= 1'b1;
		end else begin
			state <= next_state;
			busy  <= (next_state != ST_IDLE);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			held_cmd  <= '0;
			walk_addr <= '0;
			walk_end  <= '0;
		end else if (accept) begin
			held_cmd  <= cmd;
			walk_addr <= erase_beg;
			walk_end  <= erase_end;
		end else if (state == ST_ERASE && walk_addr != walk_end) begin
			walk_addr <= walk_addr + 1'b1;
		end
	end

	// Answer strobes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rsp <= '0;
		end else begin
			rsp.rejected <= refuse;
			rsp.done     <= (state == ST_READ) || (state == ST_WAIT && op_timer_zero);
			if (state == ST_READ) begin
				rsp.rdata     <= rdata_a;
				rsp.verify_ok <= (held_cmd.op == OP_VERIFY) && (rdata_a == held_cmd.data);
			end
		end
	end

	// Start-up reads of configuration, status byte and vector
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fx2_programmed  <= 1'b0;
			status_byte     <= '0;
			start_address   <= RESET_START;
			boot_ready      <= 1'b0;
			protection_bits <= PROT_ERASED;
		end else begin
			if (state == ST_BOOT_STAT) begin
				fx2_programmed  <= !rdata_a[FX2_BIT];
				protection_bits <= rdata_a[PROT_LSB +: PROT_BITS];
			end
			if (state == ST_BOOT_VEC)
				status_byte <= rdata_a;
			if (state == ST_BOOT_END) begin
				start_address <= (status_byte == 8'h00) ? RESET_START : {rdata_a, START_LOW_BYTE};
				boot_ready    <= 1'b1;
			end
			if (accept && is_chip)
				protection_bits <= PROT_ERASED;
			else if (cfg_write)
				protection_bits <= cmd.data[PROT_LSB +: PROT_BITS];
			else if (state == ST_PROT_RD)
				protection_bits <= prot_byte[PROT_LSB +: PROT_BITS];
		end
	end

	// External access pin synchroniser and fetch routing
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ea_meta      <= 1'b1;
			ea_sync_n    <= 1'b1;
			fetch_valid  <= 1'b0;
			fetch_source <= SRC_USER_FLASH;
		end else begin
			ea_meta     <= external_access_input_n;
			ea_sync_n   <= ea_meta;
			fetch_valid <= fetch_req;
			if (fetch_req)
				fetch_source <= next_source;
		end
	end

	// Machine cycle pacing
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			six_clock_mode     <= 1'b0;
			machine_cycle_tick <= 1'b0;
		end else begin
			six_clock_mode     <= next_six;
			machine_cycle_tick <= div_zero;
		end
	end

	a_busy_rejects: assert property (@(posedge sys_clk) disable iff (reset)
		(cmd_valid && busy) |=> rsp.rejected)
		else $error("command taken while busy");

	a_prog_timing: assert property (@(posedge sys_clk) disable iff (reset)
		(accept && cmd.op == OP_PROGRAM) |=> busy [*8] ##72 (!busy && rsp.done))
		else $error("byte program did not end after its timed interval");

	a_read_answer: assert property (@(posedge sys_clk) disable iff (reset)
		(accept && (cmd.op == OP_READ || cmd.op == OP_VERIFY)) |-> ##2 (rsp.done && !busy))
		else $error("read answer not given two cycles after acceptance");

	a_parallel_locked: assert property (@(posedge sys_clk) disable iff (reset)
		(cmd_valid && cmd.parallel && protection_bits != PROT_ERASED && cmd.op != OP_CHIP_ERASE)
		|=> (rsp.rejected && !$rose(busy)))
		else $error("parallel access passed despite protection");

	a_security_kept: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ST_ERASE && held_cmd.op == OP_BLOCK_ERASE) |-> (walk_addr[FLASH_AW-1:BLOCK_AW] != SECURITY_BLOCK))
		else $error("block erase reached the security block");

	a_six_clock_period: assert property (@(posedge sys_clk) disable iff (reset)
		($past(six_clock_mode) && machine_cycle_tick && $past(next_six)) |-> ##6 machine_cycle_tick)
		else $error("6-clock machine cycle period wrong");

	a_twelve_clock_gap: assert property (@(posedge sys_clk) disable iff (reset)
		(machine_cycle_tick && $past(!next_six)) |=> !machine_cycle_tick [*8])
		else $error("12-clock machine cycle too short");

	a_fx2_forces_six: assert property (@(posedge sys_clk) disable iff (reset)
		fx2_programmed |=> six_clock_mode)
		else $error("programmed flash mode bit did not force 6-clock");

	a_fx2_held: assert property (@(posedge sys_clk) disable iff (reset)
		(state != ST_BOOT_STAT) |=> $stable(fx2_programmed))
		else $error("flash mode bit changed outside start-up");

	a_external_fetch: assert property (@(posedge sys_clk) disable iff (reset)
		(fetch_req && !ea_sync_n) |=> (fetch_source == SRC_EXTERNAL))
		else $error("internal memory used with external access low");

	a_overlay_fetch: assert property (@(posedge sys_clk) disable iff (reset)
		(fetch_req && ea_sync_n) |=> (fetch_source ==
		(($past(boot_rom_enable) && (&$past(fetch_addr[15:10]))) ? SRC_BOOT_ROM : SRC_USER_FLASH)))
		else $error("boot ROM overlay routing wrong");

	a_start_zero: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ST_BOOT_END && status_byte == 8'h00) |=> (start_address == RESET_START && boot_ready))
		else $error("zero status byte did not start at 0000H");
endmodule
`default_nettype wire

// *** tb/fmbcc_host_model.sv ***
// Command source standing in for the boot routines or a parallel programmer
`default_nettype none
module fmbcc_host_model
	import fmbcc_pkg::*;
(
	// Clock
	input  wire logic          sys_clk,
	// Command port
	output var  logic          cmd_valid,
	output var  fmbcc_cmd_type cmd,
	input  wire fmbcc_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cmd_valid = 1'b0;
		cmd       = '0;
	end

	// Again repeats the request while the first one is still running
	task automatic run(input fmbcc_cmd_type c, input bit again, output fmbcc_rsp_type r, output int n,
			output bit hit);
		n = 0;
		hit = 0;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd       <= c;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
		while (!(rsp.done === 1'b1 || (rsp.rejected === 1'b1 && !again)) && n < 80000) begin
			@(posedge sys_clk);
			if (again && n == 2) cmd_valid <= 1'b1;
			if (again && n == 3) cmd_valid <= 1'b0;
			#1;
			n++;
			if (again && n > 3 && n < 7) hit |= (rsp.rejected === 1'b1);
		end
		r = rsp;
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the flash controller
`default_nettype none
module tb
	import fmbcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ERASE_T = 4200;
	localparam int CHIP_T  = 74000;
	localparam int TIMEOUT = 92000;
	logic            sys_clk;
	logic            reset;
	logic            cmd_valid;
	fmbcc_cmd_type   cmd;
	fmbcc_rsp_type   rsp;
	logic            busy;
	logic            fetch_req;
	logic [15:0]     fetch_addr;
	logic            boot_rom_enable;
	logic            external_access_input_n;
	logic            fetch_valid;
	fmbcc_fetch_type fetch_source;
	logic [7:0]      fetch_data;
	logic            boot_ready;
	logic [15:0]     start_address;
	logic            register_clock_mode_bit;
	logic            six_clock_mode;
	logic            machine_cycle_tick;
	logic [2:0]      protection_bits;
	int              miscompares = 0;
	int              samples_checked = 0;
	int              cycles = 0;
	fmbcc_rsp_type   r;
	int              n;
	bit              hit;
	logic [16:0]     pa [6];
	logic [7:0]      pd [6];

	fmbcc_flash_ctrl #(
		.ERASE_TIME_CYCLES      (ERASE_T),
		.CHIP_ERASE_TIME_CYCLES (CHIP_T)
	) dut (
		.sys_clk, .reset, .cmd_valid, .cmd, .rsp, .busy, .fetch_req, .fetch_addr, .boot_rom_enable,
		.external_access_input_n, .fetch_valid, .fetch_source, .fetch_data, .boot_ready, .start_address,
		.register_clock_mode_bit, .six_clock_mode, .machine_cycle_tick, .protection_bits
	);

	fmbcc_host_model host (.sys_clk, .cmd_valid, .cmd, .rsp);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic int want_n(fmbcc_op_type o);
		case (o)
			OP_READ, OP_VERIFY: return 2;
			OP_BLOCK_ERASE: return ERASE_T;
			OP_CHIP_ERASE: return CHIP_T;
			default: return PROG_CYCLES;
		endcase
	endfunction

	task automatic op(input fmbcc_op_type o, input logic p, input logic [16:0] a, input logic [7:0] d,
			input bit bad = 0, input bit again = 0);
		host.run(fmbcc_cmd_type'{o, p, a[16:12], a, d}, again, r, n, hit);
		if (bad) begin
			chk("rejected", r.rejected, 1);
		end else begin
			chk("done", r.done, 1);
			// Host counts edges after the accepting one; the answer cycle count includes it
			chk("answer cycles", n + 1, want_n(o));
		end
	endtask

	task automatic rd(input logic [16:0] a, input logic [7:0] d);
		op(OP_READ, 1'b0, a, 8'h00);
		chk("rdata", r.rdata, d);
	endtask

	task automatic fe(input logic [15:0] a);
		@(posedge sys_clk);
		fetch_req  <= 1'b1;
		fetch_addr <= a;
		@(posedge sys_clk);
		fetch_req <= 1'b0;
		#1;
		chk("fetch_valid", fetch_valid, 1);
	endtask

	// Third gap is measured so a mode change has settled
	task automatic tp(input int want);
		int k;
		for (int j = 0; j < 3; j++) begin
			k = 0;
			do begin
				@(posedge sys_clk);
				#1;
				k++;
			end while (machine_cycle_tick !== 1'b1 && k < 30);
		end
		chk("tick period", k, want);
	endtask

	task automatic do_reset();
		int k;
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		chk("busy in reset", busy, 1);
		chk("prot in reset", protection_bits, PROT_ERASED);
		@(posedge sys_clk);
		reset <= 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (busy !== 1'b0 && k < 20);
		chk("start-up length", k <= 5, 1);
		chk("boot_ready", boot_ready, 1);
	endtask

	task automatic pst(input logic [7:0] s, input logic [7:0] v);
		op(OP_PROGRAM, 1'b0, {STATUS_BLOCK, STATUS_OFFSET}, s);
		op(OP_PROGRAM, 1'b0, {STATUS_BLOCK, VECTOR_OFFSET}, v);
	endtask

	initial begin
		reset = 1'b1;
		fetch_req = 1'b0;
		fetch_addr = 16'h0000;
		boot_rom_enable = 1'b1;
		external_access_input_n = 1'b1;
		register_clock_mode_bit = 1'b0;
		void'($urandom(65));
		do_reset();
		op(OP_CHIP_ERASE, 1'b1, 17'h0_0000, 8'h00);
		for (int b = 0; b < 18; b++) rd({b[4:0], 12'($urandom)}, ERASED_BYTE);
		$display("test chip_erase finished");
		do_reset();
		chk("start", start_address, {8'hff, START_LOW_BYTE});
		chk("six", six_clock_mode, 0);
		tp(12);
		register_clock_mode_bit <= 1'b1;
		tp(6);
		chk("six", six_clock_mode, 1);
		register_clock_mode_bit <= 1'b0;
		$display("test clock_mode finished");
		for (int i = 0; i < 6; i++) begin
			pa[i] = {5'(3 + i % 2), 4'(i), 8'($urandom)};
			pd[i] = 8'($urandom);
			op(OP_PROGRAM, 1'b0, pa[i], pd[i], 0, i == 0);
			if (i == 0) chk("busy refusal", hit, 1);
			rd(pa[i], pd[i]);
			op(OP_VERIFY, 1'b0, pa[i], ~pd[i]);
			chk("verify fail", r.verify_ok, 0);
			op(OP_VERIFY, 1'b0, pa[i], pd[i]);
			chk("verify pass", r.verify_ok, 1);
		end
		$display("test program finished");
		op(OP_BLOCK_ERASE, 1'b0, 17'h0_3000, 8'h00);
		for (int i = 0; i < 6; i++) rd(pa[i], (i % 2 == 0) ? ERASED_BYTE : pd[i]);
		op(OP_BLOCK_ERASE, 1'b0, {SECURITY_BLOCK, 12'h000}, 8'h00, 1);
		op(OP_READ, 1'b0, 17'h1_2000, 8'h00, 1);
		pst(8'h01, 8'h5a);
		rd({STATUS_BLOCK, VECTOR_OFFSET}, 8'h5a);
		op(OP_BLOCK_ERASE, 1'b0, {STATUS_BLOCK, 12'h000}, 8'h00);
		rd({STATUS_BLOCK, STATUS_OFFSET}, ERASED_BYTE);
		rd({STATUS_BLOCK, VECTOR_OFFSET}, ERASED_BYTE);
		pst(8'h01, 8'h5a);
		$display("test block_erase finished");
		op(OP_PROGRAM, 1'b0, 17'h0_fc10, 8'h3c);
		fe(BOOT_ROM_BASE | 16'($urandom % 1024));
		chk("source", fetch_source, SRC_BOOT_ROM);
		fe(pa[1][15:0]);
		chk("source", fetch_source, SRC_USER_FLASH);
		chk("fetch data", fetch_data, pd[1]);
		boot_rom_enable <= 1'b0;
		fe(16'hfc10);
		chk("fetch data", fetch_data, 8'h3c);
		external_access_input_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		fe(16'($urandom));
		chk("source", fetch_source, SRC_EXTERNAL);
		external_access_input_n <= 1'b1;
		boot_rom_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		$display("test fetch finished");
		op(OP_PROGRAM, 1'b0, {SECURITY_BLOCK, CFG_OFFSET}, 8'hf6);
		chk("prot", protection_bits, 3'h6);
		chk("six", six_clock_mode, 0);
		op(OP_READ, 1'b1, pa[1], 8'h00, 1);
		op(OP_PROGRAM, 1'b1, pa[1], 8'h00, 1);
		rd(pa[1], pd[1]);
		op(OP_PROTECT, 1'b0, {SECURITY_BLOCK, CFG_OFFSET}, 8'h01);
		chk("prot", protection_bits, 3'h4);
		do_reset();
		chk("start", start_address, 16'h5a00);
		chk("six", six_clock_mode, 1);
		tp(6);
		op(OP_PROGRAM, 1'b0, {STATUS_BLOCK, STATUS_OFFSET}, 8'h00);
		do_reset();
		chk("start", start_address, RESET_START);
		$display("test config finished");
		report_and_stop();
	end
endmodule
`default_nettype wire
